// File: verilog/rio_table_pkg.sv
// constants and carrier types for the remote i/o table master
package rio_table_pkg;
   localparam int          WORD_W         = 16;
   localparam int          ADDR_W         = 16;
   localparam int          STN_W          = 3;
   localparam int          IDX_W          = 5;
   localparam int          MAX_SLAVES     = 7;
   localparam int          PTS_W          = 17;
   localparam logic [4:0]  TABLE_LAST_IDX = 5'h1f;   // 32 words, last at index 31
   localparam logic [4:0]  HDR_WORDS      = 5'h04;   // reserved header words
   localparam logic [1:0]  GROUP_LAST     = 2'h3;    // fourth word of a group
   localparam logic [1:0]  WORD_IN_CNT    = 2'h1;
   localparam logic [1:0]  WORD_OUT_CNT   = 2'h3;
   localparam logic [16:0] MAX_POINTS     = 17'h00800; // 2048 points per channel
   localparam logic [15:0] DEFAULT_BASE   = 16'h3fc0;  // pointer example 37700 octal
   localparam logic [2:0]  MASTER_STATION = 3'h0;
   localparam logic [2:0]  STN_NONE       = 3'h0;

   typedef struct packed {
      logic [15:0] in_addr;
      logic [15:0] in_count;
      logic [15:0] out_addr;
      logic [15:0] out_count;
   } slave_cfg_t;

   typedef struct packed {
      logic [2:0] station;
      slave_cfg_t cfg;
   } poll_req_t;
endpackage

// File: verilog/slave_table_mem.sv
// seven-entry slave description store with registered read
`timescale 1ns/10ps
module slave_table_mem
(
   // clock and reset
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst,
   // write side
   input  wire logic                    i_wr_en,
   input  wire logic [2:0]              i_wr_addr,
   input  wire rio_table_pkg::slave_cfg_t i_wr_data,
   // read side
   input  wire logic [2:0]              i_rd_addr,
   output rio_table_pkg::slave_cfg_t    o_rd_data
);
   import rio_table_pkg::*;

   slave_cfg_t mem [0:MAX_SLAVES-1];
   slave_cfg_t rd_reg;

   assign o_rd_data = rd_reg;

   // array left without reset; only entries written at load are ever read
   always_ff @(posedge i_clk_sys)
   begin
      if (i_wr_en)
      begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         rd_reg <= '0;
      end
      else
      begin
         // no station selected reads as zero instead of an entry past the end
         if (i_rd_addr < 3'(MAX_SLAVES))
         begin
            rd_reg <= mem[i_rd_addr];
         end
         else
         begin
            rd_reg <= '0;
         end
      end
   end
endmodule

// File: verilog/remote_io_table_master.sv
// loads the remote i/o configuration table and sequences slave polls
//
// Functional notes
// RULE_01: the table starts at the word address given by the port setup base input.
// RULE_02: the table is read as consecutive four-word groups, one per slave in order.
// RULE_03: the first four words are skipped as reserved, slave one starts at word five.
// RULE_04: the table is read once, never again, and slave data come from that read.
// RULE_05: group words are input start, input count, output start, output count.
// RULE_06: exactly 32 words are read, header plus seven groups ending at the last word.
// RULE_07: software zeroes every word of each unused slave group.
// RULE_08: a group holding any nonzero word marks a present slave, all zero means none.
// RULE_09: software writes the table once at power-up before flagging setup done.
// RULE_10: link work begins when the setup-complete flag becomes set.
// RULE_11: the captured pointer value is the table base, 37700 octal by example.
// RULE_12: this end is link master at station zero, slaves use stations one to seven.
// RULE_13: at most seven slaves and 2048 points are handled on the channel.
// RULE_14: nothing is offered to the link from reset until the flag is seen set.
// RULE_15: only present slaves are polled, in ascending station order each cycle.
`timescale 1ns/10ps
module remote_io_table_master
(
   // clock and reset
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst,
   // setup from the program
   input  wire logic [15:0]                i_table_base,
   input  wire logic                       i_setup_complete_flag,
   // word memory read port
   output logic                            o_mem_rd_req,
   output logic [15:0]                     o_mem_addr,
   input  wire logic [15:0]                i_mem_rd_data,
   input  wire logic                       i_mem_rd_valid,
   // link poll request
   output logic                            o_poll_valid,
   output rio_table_pkg::poll_req_t        o_poll,
   input  wire logic                       i_poll_ready,
   // status
   output logic                            o_link_active,
   output logic [6:0]                      o_slave_present,
   output logic                            o_points_over,
   output logic [2:0]                      o_master_station
);
   import rio_table_pkg::*;

   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] next_station(input logic [6:0] pres,
                                               input logic [2:0] cur);
      logic [2:0] found;
      int         s;
      found = STN_NONE;
      // walk downward so the nearest station after cur wins
      for (int k = MAX_SLAVES; k >= 1; k--)
      begin
         s = ((int'(cur) + k - 1) % MAX_SLAVES) + 1;
         if (pres[s-1])
         begin
            found = 3'(s);
         end
      end
      return found;
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      ST_WAIT_SETUP = 3'h0,
      ST_LOAD_REQ   = 3'h1,
      ST_LOAD_WAIT  = 3'h3,
      ST_FETCH      = 3'h2,
      ST_OFFER      = 3'h6,
      ST_NO_SLAVE   = 3'h7
   } state_t;

   state_t      state_reg, state_next;
   logic [4:0]  idx_reg, idx_next;
   logic [15:0] base_reg, base_next;
   logic [47:0] acc_reg, acc_next;
   logic        nz_reg, nz_next;
   logic [6:0]  pres_reg, pres_next;
   logic [16:0] pts_reg, pts_next;
   logic [2:0]  stn_reg, stn_next;
   logic        flag_d_reg;
   logic        active_reg, active_next;
   logic        wr_en;
   logic [2:0]  wr_addr;
   slave_cfg_t  wr_data;
   slave_cfg_t  rd_data;
   logic        flag_rise;

   assign flag_rise        = i_setup_complete_flag && !flag_d_reg;
   assign o_mem_addr       = base_reg + 16'(idx_reg);          // RULE_01
   assign o_mem_rd_req     = (state_reg == ST_LOAD_REQ);
   assign o_poll_valid     = (state_reg == ST_OFFER);          // RULE_14
   assign o_poll.station   = stn_reg;
   assign o_poll.cfg       = rd_data;
   assign o_link_active    = active_reg;
   assign o_slave_present  = pres_reg;
   assign o_points_over    = (pts_reg > MAX_POINTS);           // RULE_13
   assign o_master_station = MASTER_STATION;                   // RULE_12

   slave_table_mem u_table
   (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_wr_en   (wr_en),
      .i_wr_addr (wr_addr),
      .i_wr_data (wr_data),
      .i_rd_addr (stn_reg - 3'h1),
      .o_rd_data (rd_data)
   );

   //////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_next  = state_reg;
      idx_next    = idx_reg;
      base_next   = base_reg;
      acc_next    = acc_reg;
      nz_next     = nz_reg;
      pres_next   = pres_reg;
      pts_next    = pts_reg;
      stn_next    = stn_reg;
      active_next = active_reg;
      wr_en       = 1'b0;
      wr_addr     = idx_reg[4:2] - 3'h1;
      wr_data     = {acc_reg, i_mem_rd_data};                  // RULE_05
      unique case (state_reg)
         ST_WAIT_SETUP:
         begin
            // the table is only trusted once the program flags it written
            if (flag_rise)                                      // RULE_10
            begin
               base_next  = i_table_base;                       // RULE_11
               idx_next   = '0;
               state_next = ST_LOAD_REQ;                        // RULE_04
            end
         end
         ST_LOAD_REQ:
         begin
            state_next = ST_LOAD_WAIT;
         end
         ST_LOAD_WAIT:
         begin
            if (i_mem_rd_valid)
            begin
               if (idx_reg >= HDR_WORDS)                        // RULE_03
               begin
                  acc_next = {acc_reg[31:0], i_mem_rd_data};    // RULE_02
                  nz_next  = nz_reg || (i_mem_rd_data != '0);
                  // adding stops once over the limit so the sum can never wrap
                  if ((idx_reg[1:0] == WORD_IN_CNT || idx_reg[1:0] == WORD_OUT_CNT)
                      && pts_reg <= MAX_POINTS)
                  begin
                     pts_next = pts_reg + PTS_W'(i_mem_rd_data);
                  end
                  if (idx_reg[1:0] == GROUP_LAST)
                  begin
                     wr_en   = 1'b1;
                     nz_next = 1'b0;
                     pres_next[wr_addr] = nz_reg || (i_mem_rd_data != '0); // RULE_08
                  end
               end
               if (idx_reg == TABLE_LAST_IDX)                   // RULE_06
               begin
                  active_next = 1'b1;
                  stn_next    = next_station(pres_next, STN_NONE);
                  state_next  = (stn_next == STN_NONE) ? ST_NO_SLAVE : ST_FETCH;
               end
               else
               begin
                  idx_next   = idx_reg + 5'h1;
                  state_next = ST_LOAD_REQ;
               end
            end
         end
         ST_FETCH:
         begin
            state_next = ST_OFFER;
         end
         ST_OFFER:
         begin
            if (i_poll_ready)
            begin
               stn_next   = next_station(pres_reg, stn_reg);    // RULE_15
               state_next = ST_FETCH;
            end
         end
         ST_NO_SLAVE:
         begin
            state_next = ST_NO_SLAVE;
         end
         default:
         begin
            state_next = ST_WAIT_SETUP;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_reg  <= ST_WAIT_SETUP;
         idx_reg    <= '0;
         base_reg   <= DEFAULT_BASE;
         acc_reg    <= '0;
         nz_reg     <= 1'b0;
         pres_reg   <= '0;
         pts_reg    <= '0;
         stn_reg    <= STN_NONE;
         flag_d_reg <= 1'b0;
         active_reg <= 1'b0;
      end
      else
      begin
         state_reg  <= state_next;
         idx_reg    <= idx_next;
         base_reg   <= base_next;
         acc_reg    <= acc_next;
         nz_reg     <= nz_next;
         pres_reg   <= pres_next;
         pts_reg    <= pts_next;
         stn_reg    <= stn_next;
         flag_d_reg <= i_setup_complete_flag;
         active_reg <= active_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   idle_before_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_14
      !o_link_active |-> !o_poll_valid)
      else $error("poll offered before setup completed");

   load_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_10
      (state_reg == ST_WAIT_SETUP && flag_rise) |=> o_mem_rd_req
      && o_mem_addr == $past(i_table_base))
      else $error("table read did not start at flag rise");

   read_once_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_04
      o_link_active |-> !o_mem_rd_req)
      else $error("table read again after load");

   addr_in_table_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_06
      o_mem_rd_req |-> (o_mem_addr - base_reg) <= 16'(TABLE_LAST_IDX))
      else $error("read outside the 32 word table");

   poll_present_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_15
      o_poll_valid |-> o_poll.station != STN_NONE && o_slave_present[o_poll.station - 3'h1])
      else $error("poll of absent slave");

   poll_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_15
      o_poll_valid && !i_poll_ready |=> o_poll_valid && $stable(o_poll))
      else $error("poll request dropped or changed while stalled");

   next_offer_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_15
      o_poll_valid && i_poll_ready |-> ##1 !o_poll_valid ##1 o_poll_valid)
      else $error("next poll not offered two cycles after accept");

   header_skip_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_03
      (state_reg == ST_LOAD_WAIT && i_mem_rd_valid && idx_reg < HDR_WORDS) |=> $stable(pres_reg)
      && !$past(wr_en))
      else $error("reserved header word used as slave data");

   no_slave_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_08
      o_link_active && o_slave_present == '0 |-> !o_poll_valid)
      else $error("poll with no slave present");
endmodule

// File: testbench/rio_link_partner.sv
// remote link model: accepts polls promptly or after a stall
`timescale 1ns/10ps
module rio_link_partner
(
   // clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst,
   // poll side
   input  wire logic                      i_poll_valid,
   input  wire rio_table_pkg::poll_req_t  i_poll,
   input  wire logic                      i_slow,
   output logic                           o_poll_ready,
   // accepted poll, one cycle later
   output logic                           o_acc,
   output rio_table_pkg::poll_req_t       o_acc_poll
);
   import rio_table_pkg::*;
   logic [1:0] wait_reg;

   // slow mode stalls three cycles so a held request is exercised
   assign o_poll_ready = i_poll_valid && (!i_slow || wait_reg == 2'h3);

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         wait_reg   <= 2'h0;
         o_acc      <= 1'b0;
         o_acc_poll <= '0;
      end
      else
      begin
         wait_reg   <= (i_poll_valid && !o_poll_ready) ? wait_reg + 2'h1 : 2'h0;
         o_acc      <= i_poll_valid && o_poll_ready;
         o_acc_poll <= i_poll;
      end
   end
endmodule

// File: testbench/tb_remote_io_table_master.sv
// bench for the remote i/o table master
`timescale 1ns/10ps
module tb_remote_io_table_master;
   import rio_table_pkg::*;
   typedef struct packed {
      logic [15:0] base;
      logic [6:0]  mask;
      logic        sparse;
      logic [15:0] cnt;
   } row_t;
   row_t        rows[5];
   logic        i_clk_sys = 1'b0;
   logic        i_rst = 1'b1;
   logic [15:0] i_table_base = 16'h0000;
   logic        i_setup_complete_flag = 1'b0;
   logic        o_mem_rd_req;
   logic [15:0] o_mem_addr;
   logic [15:0] i_mem_rd_data = 16'h0000;
   logic        i_mem_rd_valid = 1'b0;
   logic        o_poll_valid;
   poll_req_t   o_poll;
   logic        i_poll_ready;
   logic        o_link_active;
   logic [6:0]  o_slave_present;
   logic        o_points_over;
   logic [2:0]  o_master_station;
   logic        slow = 1'b0;
   logic        acc;
   poll_req_t   acc_poll;
   logic [15:0] tbl[32];
   int          num_errors = 0;
   int          total_checks = 0;
   int          rd_count = 0;

   always #50 i_clk_sys = ~i_clk_sys;

   remote_io_table_master dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_table_base(i_table_base), .i_setup_complete_flag(i_setup_complete_flag),
      .o_mem_rd_req(o_mem_rd_req), .o_mem_addr(o_mem_addr), .i_mem_rd_data(i_mem_rd_data),
      .i_mem_rd_valid(i_mem_rd_valid), .o_poll_valid(o_poll_valid), .o_poll(o_poll),
      .i_poll_ready(i_poll_ready), .o_link_active(o_link_active),
      .o_slave_present(o_slave_present), .o_points_over(o_points_over),
      .o_master_station(o_master_station));

   rio_link_partner link (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_poll_valid(o_poll_valid),
      .i_poll(o_poll), .i_slow(slow), .o_poll_ready(i_poll_ready), .o_acc(acc),
      .o_acc_poll(acc_poll));

   ////////////////////////////////////////
   task automatic check(input logic [66:0] seen, input logic [66:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic tick;
      @(posedge i_clk_sys);
      #1;
   endtask

   ////////////////////////////////////////
   // word memory: answers one cycle late, data scrambled when idle
   always
   begin
      @(posedge i_clk_sys);
      if (o_mem_rd_req === 1'b1)
      begin
         check(o_mem_addr, i_table_base + 16'(rd_count));
         tick;
         i_mem_rd_valid = 1'b1;
         i_mem_rd_data = tbl[rd_count % 32];
         rd_count++;
         tick;
         i_mem_rd_valid = 1'b0;
         i_mem_rd_data = ~i_mem_rd_data;
      end
   end

   function automatic logic [15:0] word_of(row_t r, int s, int j);
      if (!r.mask[s-1])
         return 16'h0000;
      if (r.sparse)
         return (j == s % 4) ? 16'(s) : 16'h0000;
      return (j % 2 == 1) ? r.cnt : 16'(256 * s + j);
   endfunction

   task automatic do_reset;
      i_rst = 1'b1;
      i_setup_complete_flag = 1'b0;
      repeat (6) @(posedge i_clk_sys);
      check(o_mem_addr, DEFAULT_BASE);
      check({o_link_active, o_poll_valid, o_mem_rd_req, o_slave_present}, 67'h0);
      #1;
      i_rst = 1'b0;
   endtask

   task automatic run_row(input row_t r);
      int pts;
      int n;
      int st;
      poll_req_t exp;
      pts = 0;
      for (int i = 0; i < 4; i++)
         tbl[i] = 16'hffff;
      for (int s = 1; s <= 7; s++)
      begin
         for (int j = 0; j < 4; j++)
            tbl[4*s+j] = word_of(r, s, j);
         pts += word_of(r, s, 1) + word_of(r, s, 3);
      end
      do_reset;
      i_table_base = r.base;
      rd_count = 0;
      repeat (4)
      begin
         tick;
         check({o_mem_rd_req, o_poll_valid}, 67'h0);
      end
      i_setup_complete_flag = 1'b1;
      n = 0;
      while (o_link_active !== 1'b1 && n < 400)
      begin
         tick;
         n++;
      end
      check(o_link_active, 1'b1);
      check(67'(rd_count), 67'd32);
      check(o_slave_present, r.mask);
      check(o_points_over, pts > 2048);
      check(o_master_station, MASTER_STATION);
      st = 0;
      for (int k = 0; k < 10 && r.mask != 7'h00; k++)
      begin
         do
            st = st % 7 + 1;
         while (!r.mask[st-1]);
         n = 0;
         while (acc !== 1'b1 && n < 40)
         begin
            tick;
            n++;
         end
         check(acc, 1'b1);
         exp.station = 3'(st);
         exp.cfg = {word_of(r, st, 0), word_of(r, st, 1), word_of(r, st, 2), word_of(r, st, 3)};
         check(acc_poll, exp);
         tick;
      end
      repeat (20)
      begin
         tick;
         if (r.mask == 7'h00)
            check(o_poll_valid, 1'b0);
      end
   endtask

   ////////////////////////////////////////
   initial
   begin
      rows[0] = '{16'h3fc0, 7'h01, 1'b0, 16'h0010};
      rows[1] = '{16'h1000, 7'h55, 1'b0, 16'h0100};
      rows[2] = '{16'h2000, 7'h7f, 1'b0, 16'h0093};
      rows[3] = '{16'h0040, 7'h4a, 1'b1, 16'h0000};
      rows[4] = '{16'h0800, 7'h00, 1'b0, 16'h0000};
      foreach (rows[i])
      begin
         slow = i[0];
         run_row(rows[i]);
         $display("row %0d done, errors %0d", i, num_errors);
      end
      // a second flag rise after loading must not reread the table
      i_setup_complete_flag = 1'b0;
      repeat (3) tick;
      i_setup_complete_flag = 1'b1;
      repeat (20) tick;
      check(67'(rd_count), 67'd32);
      $display("reload test done, errors %0d", num_errors);
      print_verdict;
   end

   // about 800 cycles expected; the margin covers slow acceptance
   initial
   begin
      repeat (20000) @(posedge i_clk_sys);
      num_errors++;
      print_verdict;
   end
endmodule
